// ### ldad_regs.svh
// Register offsets, field positions, reset values and timing counts
// Contract
// - Serve one LED conversion per full sequence
// - Priority flag starts channel 1, then points at the channel not last served
// - Result registers carry parity at bit 8
// - Store logic-supply code at 4/255 scaling
// - Store boost code at 70/255 scaling
// - Store temperature code, feeds thermal comparisons
// - Range selection picks LED voltage scaling
// - Constant dimming still gets forced conversions
// - Heat alert latched when code reaches threshold
// - Cutoff stops both channels until below alert
// - Restart automatically or on enable rising edge
// - Serial error sets latched flag
// - Open flag on on-time overflow, no disable
// - Short flag when enabled, first period masked
// - Low voltage ends off-time at zero current
// - Overcurrent latches flag and stops channel
// - Output status high while regulating current
// - Dimming level bits follow 200 ns debouncer
// - Minimum on-time flag latched, clears on read
// - On-time in 200 ns steps, held when stopped
// - Power-on flag by power-on only; reads clear
// - Reset on power-on or mode-gated pin fall
// - Nonzero interval forces periodic LED conversion
// - On-voltage updates only while dimming high
`ifndef LDAD_REGS_SVH
`define LDAD_REGS_SVH
`define LDAD_LED_STAT_ADDR 8'h15
`define LDAD_CHIP_STAT_ADDR 8'h16
`define LDAD_F_OPEN 0
`define LDAD_F_SHORT 2
`define LDAD_F_OC 4
`define LDAD_F_MINON 6
`define LDAD_F_OUTST 8
`define LDAD_F_DIMLVL 10
`define LDAD_F_PWR 0
`define LDAD_F_HEAT 1
`define LDAD_F_CUT 2
`define LDAD_F_SERR 3
`define LDAD_PAR_BIT 8
`define LDAD_RES_RST 9'h100
`define LDAD_THR_RST 8'hb3
`define LDAD_CUTOFF_CODE 8'hc8
`define LDAD_AC_VDD 3'h0
`define LDAD_AC_BOOST 3'h1
`define LDAD_AC_TEMP 3'h2
`define LDAD_AC_LED1 3'h3
`define LDAD_AC_LED2 3'h4
`define LDAD_CLK_NS 40
`define LDAD_DEB_NS 200
`define LDAD_DEB_CYC ((`LDAD_DEB_NS + `LDAD_CLK_NS - 1) / `LDAD_CLK_NS)
`define LDAD_STEP_NS 200
`define LDAD_STEP_CYC (`LDAD_STEP_NS / `LDAD_CLK_NS)
`define LDAD_OPEN_NS 50000
`define LDAD_OPEN_CYC (`LDAD_OPEN_NS / `LDAD_CLK_NS)
`endif

// ### ldad_pkg.sv
// Types shared by the diagnostics block
`default_nettype none
package ldad_pkg;
   typedef enum logic {ARB_IDLE, ARB_WAIT} ldad_arb_t;
endpackage : ldad_pkg
`default_nettype wire

// ### ldad_conv_if.sv
// Conversion request carrier between top and arbiter
`default_nettype none
interface ldad_conv_if;
   logic [1:0] req;
   logic seq_done;
   logic [8:0] ivl;
   logic gnt;
   logic gnt_ch;
   modport arb(input req, input seq_done, input ivl, output gnt,
      output gnt_ch);
   modport top(output req, output seq_done, output ivl, input gnt,
      input gnt_ch);
endinterface : ldad_conv_if
`default_nettype wire

// ### ldad_arb.sv
// LED voltage conversion arbiter
`default_nettype none
`include "ldad_regs.svh"
module ldad_arb import ldad_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   ldad_conv_if.arb cv
);
   ldad_arb_t st_q;
   logic [1:0] pend_q;
   logic [1:0] pend;
   logic [8:0] seqs_q;
   logic prio_q;
   logic frc;
   logic go;
   logic pick;

   // -------------------------------------------------------------
   // Request collection
   // -------------------------------------------------------------
   assign frc = cv.seq_done && cv.ivl != 9'h0 &&
      seqs_q == cv.ivl - 9'h1;
   assign pend = pend_q | cv.req | {2{frc}};
   assign go = st_q == ARB_IDLE && cv.seq_done && |pend;
   assign pick = (pend == 2'b11) ? prio_q : pend[1];

   always_ff @(posedge clk) begin
      if (rst || cv.ivl == 9'h0) begin
         seqs_q <= 9'h0;
      end else if (cv.seq_done) begin
         seqs_q <= frc ? 9'h0 : seqs_q + 9'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pend_q <= 2'b00;
      end else begin
         pend_q <= pend & ~(go ? (pick ? 2'b10 : 2'b01) : 2'b00);
      end
   end

   // -------------------------------------------------------------
   // Grant sequencing
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= ARB_IDLE;
         prio_q <= 1'b0;
         cv.gnt <= 1'b0;
         cv.gnt_ch <= 1'b0;
      end else begin
         cv.gnt <= go;
         unique case (st_q)
            ARB_IDLE: begin
               if (go) begin
                  st_q <= ARB_WAIT;
                  prio_q <= ~pick;
                  cv.gnt_ch <= pick;
               end
            end
            ARB_WAIT: begin
               if (cv.seq_done) begin
                  st_q <= ARB_IDLE;
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   one_serve_a: assert property (cv.gnt |-> !go ##1 !cv.gnt)
      else $error("second grant inside a sequence");
   prio_swap_a: assert property (cv.gnt |-> prio_q != cv.gnt_ch)
      else $error("priority did not move to other channel");
   both_req_c: cover property (pend == 2'b11 && go);
endmodule : ldad_arb
`default_nettype wire

// ### ldad_top.sv
// Conversion readout and diagnostic flags for a dual LED driver
`default_nettype none
`include "ldad_regs.svh"
module ldad_top import ldad_pkg::*; (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic RESET_PIN_N,
   input wire logic [2:0] FAILSAFE_MODE_FIELD,
   input wire logic [1:0] DIM_CONTROL_INPUT,
   input wire logic [1:0] BUCK_EN,
   input wire logic [1:0] HEAT_AUTO_RECOVER_EN,
   input wire logic [3:0] LED_VOLTAGE_RANGE_SEL,
   input wire logic [8:0] FORCED_CONV_INTERVAL,
   input wire logic HEAT_THR_WE,
   input wire logic [7:0] HEAT_THR_IN,
   input wire logic ADC_SEQ_DONE,
   input wire logic ADC_VALID,
   input wire logic [2:0] ADC_CHAN,
   input wire logic [7:0] ADC_CODE,
   input wire logic SERIAL_ERROR,
   input wire logic [1:0] OVERCURRENT,
   input wire logic [1:0] LOW_VOLTAGE_CMP,
   input wire logic [1:0] ZERO_CURRENT,
   input wire logic [1:0] SW_PERIOD_START,
   input wire logic [1:0] ON_PHASE,
   input wire logic [1:0] MIN_ON_HIT,
   input wire logic RD_EN,
   input wire logic [7:0] RD_ADDR,
   output logic [15:0] RD_DATA,
   output logic LED_CONV_REQ,
   output logic LED_CONV_CH,
   output logic [1:0] LED_RANGE_OUT,
   output logic [1:0] CH_RUN,
   output logic [1:0] OFF_TIME_END,
   output logic [1:0] OUTPUT_STATUS,
   output logic DIM_INPUT_LEVEL_CH1,
   output logic DIM_INPUT_LEVEL_CH2,
   output logic [7:0] HEAT_ALERT_THRESHOLD,
   output logic [8:0] VDD_RESULT,
   output logic [8:0] BOOST_VOLTAGE_CODE,
   output logic [8:0] DIE_TEMPERATURE_CODE,
   output logic [17:0] LED_STRING_VOLTAGE_CODE,
   output logic [17:0] LED_ON_VOLTAGE_CODE,
   output logic [15:0] ON_TIME_MEASURE
);
   logic rst;
   logic soft_q;
   logic [2:0] pin_s_q;
   logic pin_lvl_q;
   logic pin_fall;
   logic mode_rst;
   logic [1:0] lvl;
   logic [1:0] dfall;
   logic [1:0] open_f;
   logic [1:0] short_f;
   logic [1:0] oc_f;
   logic [1:0] minon_f;
   logic [1:0] run;
   logic cut_q;
   logic heat_q;
   logic cutf_q;
   logic serr_q;
   logic pwr_q;
   logic temp_v;
   logic heat_set;
   logic cut_set;
   logic clr_led;
   logic clr_chip;
   logic [15:0] led_stat;
   logic [15:0] chip_stat;
   ldad_conv_if cv ();

   function automatic logic [8:0] with_par(input logic [7:0] v);
      with_par = {~^v, v};
   endfunction : with_par

   // -------------------------------------------------------------
   // Reset handling
   // -------------------------------------------------------------
   assign mode_rst = FAILSAFE_MODE_FIELD[2:1] == 2'b00 ||
      FAILSAFE_MODE_FIELD[2:1] == 2'b11;
   assign pin_fall = pin_lvl_q && pin_s_q[2:1] == 2'b00;
   assign rst = RESET || soft_q;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         pin_s_q <= 3'h7;
         pin_lvl_q <= 1'b1;
         soft_q <= 1'b0;
      end else begin
         pin_s_q <= {pin_s_q[1:0], RESET_PIN_N};
         if (pin_s_q[2] == pin_s_q[1]) begin
            pin_lvl_q <= pin_s_q[2];
         end
         soft_q <= pin_fall && mode_rst;
      end
   end

   // -------------------------------------------------------------
   // Per channel input conditioning and protection
   // -------------------------------------------------------------
   for (genvar i = 0; i < 2; i++) begin : g_ch
      logic [2:0] ds_q;
      logic [2:0] dcnt_q;
      logic dlvl_q;
      logic dprev_q;
      logic [2:0] ls_q;
      logic low_q;
      logic en_prev_q;
      logic en_rise;
      logic hold_q;
      logic ocs_q;
      logic run_q;
      logic mask_q;
      logic [10:0] ocnt_q;
      logic [2:0] tcnt_q;
      logic [7:0] steps_q;
      logic onp_q;
      logic open_q;
      logic short_q;
      logic oc_q;
      logic minon_q;
      logic clr;

      assign lvl[i] = dlvl_q;
      assign dfall[i] = dprev_q && !dlvl_q;
      assign run[i] = run_q;
      assign en_rise = BUCK_EN[i] && !en_prev_q;
      assign open_f[i] = open_q;
      assign short_f[i] = short_q;
      assign oc_f[i] = oc_q;
      assign minon_f[i] = minon_q;
      assign clr = clr_led;

      always_ff @(posedge MCLK) begin
         if (rst) begin
            ds_q <= 3'h0;
            ls_q <= 3'h0;
            dcnt_q <= 3'h0;
            dlvl_q <= 1'b0;
            dprev_q <= 1'b0;
            low_q <= 1'b0;
         end else begin
            ds_q <= {ds_q[1:0], DIM_CONTROL_INPUT[i]};
            ls_q <= {ls_q[1:0], LOW_VOLTAGE_CMP[i]};
            dprev_q <= dlvl_q;
            if (ls_q[2] == ls_q[1]) begin
               low_q <= ls_q[2];
            end
            if (ds_q[2] != ds_q[1] || ds_q[2] == dlvl_q) begin
               dcnt_q <= 3'h0;
            end else if (dcnt_q == 3'(`LDAD_DEB_CYC - 1)) begin
               dlvl_q <= ds_q[2];
               dcnt_q <= 3'h0;
            end else begin
               dcnt_q <= dcnt_q + 3'h1;
            end
         end
      end

      always_ff @(posedge MCLK) begin
         if (rst) begin
            en_prev_q <= 1'b0;
            hold_q <= 1'b0;
            ocs_q <= 1'b0;
            run_q <= 1'b0;
            mask_q <= 1'b1;
         end else begin
            en_prev_q <= BUCK_EN[i];
            if (cut_q) begin
               hold_q <= 1'b1;
            end else if (HEAT_AUTO_RECOVER_EN[i] || en_rise) begin
               hold_q <= 1'b0;
            end
            if (OVERCURRENT[i]) begin
               ocs_q <= 1'b1;
            end else if (en_rise) begin
               ocs_q <= 1'b0;
            end
            run_q <= BUCK_EN[i] && !cut_q && !hold_q && !ocs_q &&
               !OVERCURRENT[i];
            if (!run_q) begin
               mask_q <= 1'b1;
            end else if (SW_PERIOD_START[i]) begin
               mask_q <= 1'b0;
            end
         end
      end

      always_ff @(posedge MCLK) begin
         if (rst) begin
            ocnt_q <= 11'h0;
            tcnt_q <= 3'h0;
            steps_q <= 8'h0;
            onp_q <= 1'b0;
            ON_TIME_MEASURE[i*8 +: 8] <= 8'h0;
         end else begin
            onp_q <= ON_PHASE[i];
            if (ON_PHASE[i] && run_q) begin
               ocnt_q <= ocnt_q + 11'h1;
            end else begin
               ocnt_q <= 11'h0;
            end
            if (ON_PHASE[i]) begin
               if (tcnt_q == 3'(`LDAD_STEP_CYC - 1)) begin
                  tcnt_q <= 3'h0;
                  if (steps_q != 8'hff) begin
                     steps_q <= steps_q + 8'h1;
                  end
               end else begin
                  tcnt_q <= tcnt_q + 3'h1;
               end
            end else begin
               tcnt_q <= 3'h0;
               steps_q <= 8'h0;
            end
            if (onp_q && !ON_PHASE[i]) begin
               ON_TIME_MEASURE[i*8 +: 8] <= steps_q;
            end
         end
      end

      always_ff @(posedge MCLK) begin
         if (rst) begin
            open_q <= 1'b0;
            short_q <= 1'b0;
            oc_q <= 1'b0;
            minon_q <= 1'b0;
         end else begin
            open_q <= (ON_PHASE[i] && run_q &&
               ocnt_q == 11'(`LDAD_OPEN_CYC - 1)) ||
               (open_q && !clr);
            short_q <= (run_q && !mask_q && low_q) ||
               (short_q && !clr);
            oc_q <= OVERCURRENT[i] || (oc_q && !clr);
            minon_q <= MIN_ON_HIT[i] || (minon_q && !clr);
         end
      end

      ovc_stop_a: assert property (@(posedge MCLK) disable iff (rst)
         OVERCURRENT[i] |=> !run_q ##1 !CH_RUN[i])
         else $error("channel kept running after overcurrent");
      short_mask_a: assert property (@(posedge MCLK) disable iff (rst)
         $rose(run_q) |=> !short_q || $past(short_q))
         else $error("short flagged in first switching period");
   end

   // -------------------------------------------------------------
   // Conversion arbitration
   // -------------------------------------------------------------
   assign cv.req = dfall;
   assign cv.seq_done = ADC_SEQ_DONE;
   assign cv.ivl = FORCED_CONV_INTERVAL;

   ldad_arb u_arb (
      .clk(MCLK),
      .rst(rst),
      .cv(cv.arb)
   );

   always_ff @(posedge MCLK) begin
      if (rst) begin
         LED_CONV_REQ <= 1'b0;
         LED_CONV_CH <= 1'b0;
         LED_RANGE_OUT <= 2'b00;
      end else begin
         LED_CONV_REQ <= cv.gnt;
         if (cv.gnt) begin
            LED_CONV_CH <= cv.gnt_ch;
            LED_RANGE_OUT <= LED_VOLTAGE_RANGE_SEL[cv.gnt_ch*2 +: 2];
         end
      end
   end

   // -------------------------------------------------------------
   // Result registers
   // -------------------------------------------------------------
   assign temp_v = ADC_VALID && ADC_CHAN == `LDAD_AC_TEMP;

   always_ff @(posedge MCLK) begin
      if (rst) begin
         VDD_RESULT <= `LDAD_RES_RST;
         BOOST_VOLTAGE_CODE <= `LDAD_RES_RST;
         DIE_TEMPERATURE_CODE <= `LDAD_RES_RST;
         LED_STRING_VOLTAGE_CODE <= {2{`LDAD_RES_RST}};
         LED_ON_VOLTAGE_CODE <= {2{`LDAD_RES_RST}};
      end else if (ADC_VALID) begin
         unique case (ADC_CHAN)
            `LDAD_AC_VDD: VDD_RESULT <= with_par(ADC_CODE);
            `LDAD_AC_BOOST: BOOST_VOLTAGE_CODE <= with_par(ADC_CODE);
            `LDAD_AC_TEMP: DIE_TEMPERATURE_CODE <= with_par(ADC_CODE);
            `LDAD_AC_LED1: begin
               LED_STRING_VOLTAGE_CODE[8:0] <= with_par(ADC_CODE);
               if (lvl[0]) begin
                  LED_ON_VOLTAGE_CODE[8:0] <= with_par(ADC_CODE);
               end
            end
            `LDAD_AC_LED2: begin
               LED_STRING_VOLTAGE_CODE[17:9] <= with_par(ADC_CODE);
               if (lvl[1]) begin
                  LED_ON_VOLTAGE_CODE[17:9] <= with_par(ADC_CODE);
               end
            end
            default: begin
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Thermal supervision
   // -------------------------------------------------------------
   assign heat_set = temp_v && ADC_CODE >= HEAT_ALERT_THRESHOLD;
   assign cut_set = temp_v && ADC_CODE >= `LDAD_CUTOFF_CODE;

   always_ff @(posedge MCLK) begin
      if (rst) begin
         HEAT_ALERT_THRESHOLD <= `LDAD_THR_RST;
         cut_q <= 1'b0;
      end else begin
         if (HEAT_THR_WE) begin
            HEAT_ALERT_THRESHOLD <= HEAT_THR_IN;
         end
         if (cut_set) begin
            cut_q <= 1'b1;
         end else if (temp_v && ADC_CODE < HEAT_ALERT_THRESHOLD) begin
            cut_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // Status registers and clear on read
   // -------------------------------------------------------------
   assign clr_led = RD_EN && RD_ADDR == `LDAD_LED_STAT_ADDR;
   assign clr_chip = RD_EN && RD_ADDR == `LDAD_CHIP_STAT_ADDR;

   always_comb begin
      led_stat = 16'h0;
      led_stat[`LDAD_F_OPEN +: 2] = open_f;
      led_stat[`LDAD_F_SHORT +: 2] = short_f;
      led_stat[`LDAD_F_OC +: 2] = oc_f;
      led_stat[`LDAD_F_MINON +: 2] = minon_f;
      led_stat[`LDAD_F_OUTST +: 2] = OUTPUT_STATUS;
      led_stat[`LDAD_F_DIMLVL +: 2] = lvl;
      chip_stat = 16'h0;
      chip_stat[`LDAD_F_PWR] = pwr_q;
      chip_stat[`LDAD_F_HEAT] = heat_q;
      chip_stat[`LDAD_F_CUT] = cutf_q;
      chip_stat[`LDAD_F_SERR] = serr_q;
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         pwr_q <= 1'b1;
      end else if (clr_chip) begin
         pwr_q <= 1'b0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (rst) begin
         heat_q <= 1'b0;
         cutf_q <= 1'b0;
         serr_q <= 1'b0;
      end else begin
         heat_q <= heat_set || (heat_q && !clr_chip);
         cutf_q <= cut_set || (cutf_q && !clr_chip);
         serr_q <= SERIAL_ERROR || (serr_q && !clr_chip);
      end
   end

   always_ff @(posedge MCLK) begin
      if (rst) begin
         RD_DATA <= 16'h0;
         CH_RUN <= 2'b00;
         OFF_TIME_END <= 2'b00;
         OUTPUT_STATUS <= 2'b00;
         DIM_INPUT_LEVEL_CH1 <= 1'b0;
         DIM_INPUT_LEVEL_CH2 <= 1'b0;
      end else begin
         RD_DATA <= clr_led ? led_stat : clr_chip ? chip_stat : 16'h0;
         CH_RUN <= run;
         OFF_TIME_END <= {2{!cut_q}} & ~ON_PHASE & ZERO_CURRENT &
            {g_ch[1].low_q, g_ch[0].low_q};
         OUTPUT_STATUS <= run & lvl;
         DIM_INPUT_LEVEL_CH1 <= lvl[0];
         DIM_INPUT_LEVEL_CH2 <= lvl[1];
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (rst);

   par_odd_a: assert property (^VDD_RESULT && ^BOOST_VOLTAGE_CODE &&
      ^DIE_TEMPERATURE_CODE && ^LED_STRING_VOLTAGE_CODE[8:0])
      else $error("result parity not odd");
   heat_set_a: assert property (heat_set |=> heat_q)
      else $error("heat alert not latched");
   cut_stop_a: assert property (cut_q |=> ##1 CH_RUN == 2'b00)
      else $error("channel running during cutoff");
   serr_keep_a: assert property (SERIAL_ERROR && clr_chip |=> serr_q)
      else $error("serial error lost on read");
   pwr_once_a: assert property (!pwr_q |=> !pwr_q)
      else $error("power flag set without power-on");
   onv_hold_a: assert property (ADC_VALID && ADC_CHAN == `LDAD_AC_LED1 &&
      !lvl[0] |=> $stable(LED_ON_VOLTAGE_CODE[8:0]))
      else $error("on voltage updated while dim low");
   clr_read_a: assert property (clr_led && !OVERCURRENT[0] |=>
      !oc_f[0])
      else $error("flag survived clearing read");
   grant_c: cover property (LED_CONV_REQ);
   cut_c: cover property ($rose(cut_q));
   soft_c: cover property (pin_fall && mode_rst);
endmodule : ldad_top
`default_nettype wire

// ### ldad_mcu_model.sv
// External controller model reading status over the read port
`default_nettype none
module ldad_mcu_model (
   input wire logic clk,
   output logic rd_en,
   output logic [7:0] rd_addr,
   input wire logic [15:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      rd_en = 1'b0;
      rd_addr = 8'h00;
   end

   // ----------------------------------------
   // One status read, taken at the next edge
   // ----------------------------------------
   task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      #1;
      rd_en = 1'b1;
      rd_addr = a;
      @(posedge clk);
      #1;
      d = rd_data;
      rd_en = 1'b0;
      rd_addr = ~a;
   endtask : read_reg
endmodule : ldad_mcu_model
`default_nettype wire

// ### led_driver_adc_diagnostics_tb.sv
// Testbench for the diagnostics and readout block
`default_nettype none
module led_driver_adc_diagnostics_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, rpn, twe, sqd, avl, serr, rde, creq, cch;
   logic [2:0] fsm, ach;
   logic [1:0] dim, en, arc, oc, lvc, zc, swp, onp, mot, run;
   logic [3:0] rng;
   logic [8:0] ivl, vdd, bst, tmp;
   logic [7:0] tin, code, rda, thr;
   logic [15:0] rdd;
   logic [17:0] vled, von;
   logic dl1, dl2;
   logic [1:0] rout, ote, ost;
   logic [15:0] ont;
   int bad_count = 0;
   int check_count = 0;

   ldad_top i_ldad_top (.MCLK(clk), .RESET(rst), .RESET_PIN_N(rpn),
      .FAILSAFE_MODE_FIELD(fsm), .DIM_CONTROL_INPUT(dim), .BUCK_EN(en),
      .HEAT_AUTO_RECOVER_EN(arc), .LED_VOLTAGE_RANGE_SEL(rng),
      .FORCED_CONV_INTERVAL(ivl), .HEAT_THR_WE(twe), .HEAT_THR_IN(tin),
      .ADC_SEQ_DONE(sqd), .ADC_VALID(avl), .ADC_CHAN(ach), .ADC_CODE(code),
      .SERIAL_ERROR(serr), .OVERCURRENT(oc), .LOW_VOLTAGE_CMP(lvc),
      .ZERO_CURRENT(zc), .SW_PERIOD_START(swp), .ON_PHASE(onp),
      .MIN_ON_HIT(mot), .RD_EN(rde), .RD_ADDR(rda), .RD_DATA(rdd),
      .LED_CONV_REQ(creq), .LED_CONV_CH(cch), .LED_RANGE_OUT(rout),
      .CH_RUN(run), .OFF_TIME_END(ote), .OUTPUT_STATUS(ost),
      .DIM_INPUT_LEVEL_CH1(dl1), .DIM_INPUT_LEVEL_CH2(dl2),
      .HEAT_ALERT_THRESHOLD(thr), .VDD_RESULT(vdd),
      .BOOST_VOLTAGE_CODE(bst), .DIE_TEMPERATURE_CODE(tmp),
      .LED_STRING_VOLTAGE_CODE(vled), .LED_ON_VOLTAGE_CODE(von),
      .ON_TIME_MEASURE(ont));
   ldad_mcu_model i_ldad_mcu_model (.clk(clk), .rd_en(rde), .rd_addr(rda),
      .rd_data(rdd));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic adc(input logic [2:0] c, input logic [7:0] v);
      ach = c;
      code = v;
      avl = 1'b1;
      tick(1);
      avl = 1'b0;
      tick(1);
   endtask : adc

   task automatic rd(input logic [7:0] a, input logic [15:0] m,
      input logic [15:0] e);
      logic [15:0] d;
      i_ldad_mcu_model.read_reg(a, d);
      chk({2'h0, d & m}, {2'h0, e});
   endtask : rd

   // Sequence end; report whether and which channel was granted
   task automatic seq(input logic g, input logic c);
      logic hit;
      logic ch;
      hit = 1'b0;
      ch = 1'b0;
      sqd = 1'b1;
      tick(1);
      sqd = 1'b0;
      repeat (4) begin
         if (creq === 1'b1) begin
            hit = 1'b1;
            ch = cch;
         end
         tick(1);
      end
      chk({16'h0, hit, ch}, {16'h0, g, g & c});
   endtask : seq

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rpn, fsm, dim, en, arc, oc, lvc, zc, swp, onp, mot} = 22'h200000;
      {rst, twe, sqd, avl, serr, rng, ivl, tin, ach, code} = 37'h1;
      rst = 1'b1;
      tick(10);
      rst = 1'b0;
      tick(1);
      chk(vdd, 9'h100);
      chk(thr, 8'hb3);
      rd(8'h16, 16'h0001, 16'h0001);
      rd(8'h16, 16'h0001, 16'h0000);
      rd(8'h40, 16'hffff, 16'h0000);
      adc(3'h0, 8'h01);
      chk(vdd, 9'h001);
      adc(3'h0, 8'h00);
      chk(vdd, 9'h100);
      adc(3'h1, 8'h03);
      chk(bst, 9'h103);
      adc(3'h3, 8'h07);
      chk(vled[8:0], 9'h007);
      chk(von[8:0], 9'h100);
      adc(3'h2, 8'hb2);
      rd(8'h16, 16'h0002, 16'h0000);
      adc(3'h2, 8'hb3);
      chk(tmp, 9'h0b3);
      rd(8'h16, 16'h0002, 16'h0002);
      serr = 1'b1;
      tick(1);
      serr = 1'b0;
      rd(8'h16, 16'h0008, 16'h0008);
      en = 2'b11;
      arc = 2'b01;
      tick(3);
      chk(run, 2'b11);
      adc(3'h2, 8'hc8);
      tick(2);
      chk(run, 2'b00);
      rd(8'h16, 16'h0004, 16'h0004);
      adc(3'h2, 8'h10);
      tick(3);
      chk(run, 2'b01);
      en = 2'b01;
      tick(2);
      en = 2'b11;
      tick(3);
      chk(run, 2'b11);
      oc = 2'b01;
      tick(1);
      oc = 2'b00;
      tick(3);
      chk(run, 2'b10);
      rd(8'h15, 16'h0030, 16'h0010);
      mot = 2'b10;
      tick(1);
      mot = 2'b00;
      rd(8'h15, 16'h00c0, 16'h0080);
      rd(8'h15, 16'h00c0, 16'h0000);
      tin = 8'hc0;
      twe = 1'b1;
      tick(1);
      twe = 1'b0;
      tick(1);
      chk(thr, 8'hc0);
      dim = 2'b11;
      tick(20);
      chk({dl2, dl1}, 2'b11);
      chk(ost, 2'b10);
      rd(8'h15, 16'h0f00, 16'h0e00);
      adc(3'h4, 8'h05);
      chk(von[17:9], 9'h105);
      dim = 2'b00;
      rng = 4'h9;
      tick(20);
      seq(1'b1, 1'b0);
      chk(rout, 2'b01);
      seq(1'b0, 1'b0);
      seq(1'b1, 1'b1);
      chk(rout, 2'b10);
      seq(1'b0, 1'b0);
      ivl = 9'h2;
      seq(1'b0, 1'b0);
      seq(1'b1, 1'b0);
      seq(1'b0, 1'b0);
      seq(1'b1, 1'b1);
      ivl = 9'h0;
      lvc = 2'b10;
      zc = 2'b10;
      tick(5);
      chk(ote, 2'b10);
      rd(8'h15, 16'h000c, 16'h0000);
      swp = 2'b10;
      tick(1);
      swp = 2'b00;
      rd(8'h15, 16'h000c, 16'h0008);
      {lvc, zc} = 4'h0;
      onp = 2'b10;
      tick(1250);
      onp = 2'b00;
      tick(2);
      chk(ont, 16'hfa00);
      chk(run, 2'b10);
      rd(8'h15, 16'h0003, 16'h0002);
      adc(3'h0, 8'h01);
      rpn = 1'b0;
      tick(8);
      rpn = 1'b1;
      tick(2);
      chk(vdd, 9'h100);
      rd(8'h16, 16'h0001, 16'h0000);
      complete_run;
   end

   // Watchdog, well beyond the expected run of about 1430 cycles
   initial begin
      #200000;
      bad_count++;
      complete_run;
   end
endmodule : led_driver_adc_diagnostics_tb
`default_nettype wire
